// *** rtl/cache_map_defs.svh ***
// Purpose: constants for the mapped cache array access port
// Assumes: 32-bit longword accesses, 20 MHz core clock
// Notes: addresses are decoded from the request address field
`ifndef CACHE_MAP_DEFS_SVH
`define CACHE_MAP_DEFS_SVH

`define TAG_AREA_CODE 8'hF4
`define DATA_AREA_CODE 8'hF5
`define INS_AREA_CODE 8'hF1
`define AREA_HI 31
`define AREA_LO 24
`define NORM_WAY_BIT 14
`define RAM_WAY_BIT 13
`define INS_WAY_BIT 13
`define ASSOC_BIT 3
`define LW_HI 4
`define LW_LO 2
`define ENT_LO 5
`define TAG_HI 31
`define TAG_LO 10
`define TAG_W 19
`define DIRTY_BIT 1
`define VALID_BIT 0
`define ENT_W 9
`define WB_LINE_WORDS 4'h8

`endif

// *** rtl/cache_map_pkg.sv ***
// Purpose: types for the mapped cache array access port
// Assumes: constants come from cache_map_defs.svh
// Notes: types only
package cache_map_pkg;
   typedef logic [18:0] tag_t;
   typedef logic [8:0] entry_t;
   typedef logic [2:0] lw_t;
   typedef enum logic [1:0] {
      OP_TAG_READ,
      OP_TAG_WRITE,
      OP_DATA_READ,
      OP_DATA_WRITE
   } op_e;
endpackage : cache_map_pkg

// *** rtl/cache_line_ram.sv ***
// Purpose: synchronous longword memory for one cache data array
// Assumes: single port, one access per cycle
// Notes: read data comes out of a register
`timescale 1ns/10ps
`default_nettype none
module cache_line_ram #(
   parameter int ADDR_W = 13
) (
   input wire logic i_clk_sys,
   input wire logic i_we,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge i_clk_sys)
   begin
      if (i_we)
      begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule : cache_line_ram
`default_nettype wire

// *** rtl/mapped_cache_array_access.sv ***
// Purpose: memory-mapped access to operand cache tags and data and instruction cache data
// Assumes: requester holds request until o_ack; longword accesses only
// Notes: write-back streams the line on o_wb_* with valid/ready handshake
// Behaviour
// [R1] top byte F4 selects operand tag array
// [R2] normal mode: way bit 14, entry 13:5
// [R3] ram mode: way from address bit 13
// [R4] address bit 3 selects associative write
// [R5] data: tag 31:10, dirty 1, valid 0
// [R6] 19-bit tag; 31:29 only for associative
// [R7] tag read returns entry, never associative
// [R8] direct write stores tag, dirty, valid
// [R9] dirty valid line written back before overwrite
// [R10] associative write compares all ways of entry
// [R11] translate virtual tag when translation enabled
// [R12] hit on valid way updates flags only
// [R13] clearing flag of dirty hit writes back
// [R14] miss or mismatch silently drops the write
// [R15] multiple translation hits raise exception
// [R16] top byte F5 selects operand data array
// [R17] requester uses longwords, address bits 1:0 zero
// [R18] data read returns selected longword
// [R19] data write leaves dirty flag untouched
// [R20] instruction data write stores selected longword
// [R21] normal mode image repeats every 32 kbytes
// [R22] ram mode image repeats every 16 kbytes
// [R23] top byte F1, way 13, entry 12:5
// [R24] stall request until write-back completes
`timescale 1ns/10ps
`default_nettype none
`include "cache_map_defs.svh"
module mapped_cache_array_access (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_ram_mode_bit,
   input wire logic i_index_mode_bit,
   input wire logic i_xlat_en,
   output logic o_xlat_req,
   output logic [21:0] o_xlat_vpn,
   input wire logic i_xlat_done,
   input wire logic i_xlat_hit,
   input wire logic i_xlat_multi,
   input wire logic [18:0] i_xlat_ptag,
   output logic o_ack,
   output logic [31:0] o_rdata,
   output logic o_multi_hit_exc,
   output logic o_wb_valid,
   output logic [31:0] o_wb_addr,
   output logic [31:0] o_wb_data,
   input wire logic i_wb_ready
);
   import cache_map_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_XLAT,
      ST_LOOK,
      ST_WB_RD,
      ST_WB_SEND,
      ST_COMMIT,
      ST_RDWAIT,
      ST_DONE
   } state_e;

   state_e state;
   state_e next_state;

   // tag store: small, so kept in flops for same-cycle compare of both ways
   tag_t tag_mem [0:1][0:511];
   logic dirty_mem [0:1][0:511];
   logic valid_mem [0:1][0:511];

   // decoding
   wire [7:0] area = i_addr[`AREA_HI:`AREA_LO];
   wire sel_tag = (area == `TAG_AREA_CODE); // [R1]
   wire sel_op_data = (area == `DATA_AREA_CODE); // [R16]
   wire sel_ins_data = (area == `INS_AREA_CODE); // [R23]
   wire hit_area = sel_tag | sel_op_data | sel_ins_data;
   // o_ack is still high on the first idle cycle, so a held request is not taken twice
   wire take = (state == ST_IDLE) && i_req && !o_ack;
   // index mode has no effect on mapped accesses
   wire unused_ok = i_index_mode_bit; // [R2]
   // higher address bits ignored: images shadow through the window
   wire way_sel = i_ram_mode_bit ? i_addr[`RAM_WAY_BIT] : i_addr[`NORM_WAY_BIT]; // [R3] [R2] [R21] [R22]
   wire [8:0] ent_sel = i_ram_mode_bit ? {1'b0, i_addr[12:`ENT_LO]} : i_addr[13:`ENT_LO]; // [R22] [R21]
   wire ins_way = i_addr[`INS_WAY_BIT]; // [R23]
   wire [7:0] ins_ent = i_addr[12:`ENT_LO]; // [R23]
   wire [2:0] lw_sel = i_addr[`LW_HI:`LW_LO]; // [R16] [R17]
   wire assoc = i_addr[`ASSOC_BIT]; // [R4]
   // 19-bit tag is data 28:10; 31:29 only reach the translator
   wire [18:0] wtag = i_wdata[28:`TAG_LO]; // [R5] [R6]
   wire wdirty = i_wdata[`DIRTY_BIT]; // [R5]
   wire wvalid = i_wdata[`VALID_BIT]; // [R5]

   // registered copy of request
   logic wb_way;
   logic [8:0] ent;
   logic [2:0] wb_cnt;
   logic hit_way;
   logic do_assoc;
   tag_t cmp_tag;
   logic multi_exc;

   function automatic logic [31:0] pack_tag(input tag_t t, input logic d, input logic v);
      pack_tag = {3'b000, t, 8'h00, d, v};
   endfunction : pack_tag

   // associative lookup on both ways of the entry
   wire [1:0] way_hit;
   assign way_hit[0] = valid_mem[0][ent] && (tag_mem[0][ent] == cmp_tag); // [R10] [R12]
   assign way_hit[1] = valid_mem[1][ent] && (tag_mem[1][ent] == cmp_tag); // [R10] [R12]
   wire any_hit = |way_hit;
   wire sel_hit_way = way_hit[1];
   wire hit_dirty = dirty_mem[sel_hit_way][ent];
   wire assoc_wb = any_hit && hit_dirty && (!wdirty || !wvalid); // [R13]
   wire direct_wb = dirty_mem[wb_way][ent] && valid_mem[wb_way][ent]; // [R9]

   // data arrays
   wire op_ram_we = take && sel_op_data && i_we;
   wire ins_ram_we = take && sel_ins_data && i_we;
   wire in_wb = (state == ST_WB_RD) || (state == ST_WB_SEND);
   // ram read data is registered, so the write-back address runs one word ahead
   wire wb_fetch = (state == ST_LOOK) || in_wb;
   wire wb_src_way = (state == ST_LOOK) ? (do_assoc ? sel_hit_way : wb_way) : hit_way;
   wire [2:0] wb_step = wb_cnt + 3'd1;
   wire [2:0] wb_lw = (state == ST_LOOK) ? 3'd0 : ((state == ST_WB_SEND && i_wb_ready) ? wb_step : wb_cnt);
   wire [12:0] op_ram_addr = wb_fetch ? {wb_src_way, ent, wb_lw} : {way_sel, ent_sel, lw_sel}; // [R16] [R9]
   wire [11:0] ins_ram_addr = {ins_way, ins_ent, lw_sel}; // [R20]
   logic [31:0] op_rdata;
   logic [31:0] ins_rdata;

   cache_line_ram #(.ADDR_W(13)) u_op_ram (
      .i_clk_sys(i_clk_sys),
      .i_we(op_ram_we), // [R19]
      .i_addr(op_ram_addr),
      .i_wdata(i_wdata),
      .o_rdata(op_rdata)
   );

   cache_line_ram #(.ADDR_W(12)) u_ins_ram (
      .i_clk_sys(i_clk_sys),
      .i_we(ins_ram_we), // [R20]
      .i_addr(ins_ram_addr),
      .i_wdata(i_wdata),
      .o_rdata(ins_rdata)
   );

   logic rd_op;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
         begin
            if (take)
            begin
               if (!hit_area || !i_we)
               begin
                  if (sel_op_data || sel_ins_data)
                     next_state = ST_RDWAIT; // [R18]
                  else
                     next_state = ST_DONE;
               end
               else if (sel_tag && assoc)
                  next_state = i_xlat_en ? ST_XLAT : ST_LOOK; // [R11]
               else if (sel_tag)
                  next_state = ST_LOOK;
               else
                  next_state = ST_DONE;
            end
         end
         ST_XLAT:
         begin
            if (i_xlat_done)
               next_state = (i_xlat_hit && !i_xlat_multi) ? ST_LOOK : ST_DONE; // [R14] [R15]
         end
         ST_LOOK:
         begin
            // if, not a select: flags of a never written line must not poison the state
            if (do_assoc)
            begin
               if (assoc_wb)
                  next_state = ST_WB_RD; // [R13]
               else if (any_hit)
                  next_state = ST_COMMIT; // [R12]
               else
                  next_state = ST_DONE; // [R14]
            end
            else if (direct_wb)
               next_state = ST_WB_RD; // [R9]
            else
               next_state = ST_COMMIT; // [R8]
         end
         ST_WB_RD:
            next_state = ST_WB_SEND;
         ST_WB_SEND:
         begin
            if (i_wb_ready)
               next_state = (wb_cnt == 3'd7) ? ST_COMMIT : ST_WB_RD; // [R24]
         end
         ST_COMMIT:
            next_state = ST_DONE;
         ST_RDWAIT:
            next_state = ST_DONE;
         ST_DONE:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // request capture and handshake registers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         wb_way <= 1'b0;
         ent <= 9'h000;
         cmp_tag <= 19'h0_0000;
         do_assoc <= 1'b0;
         rd_op <= 1'b0;
         o_xlat_req <= 1'b0;
         o_xlat_vpn <= 22'h00_0000;
         multi_exc <= 1'b0;
      end
      else
      begin
         if (take)
         begin
            wb_way <= way_sel;
            ent <= ent_sel;
            cmp_tag <= wtag;
            do_assoc <= sel_tag && i_we && assoc; // [R4] [R8]
            rd_op <= sel_op_data;
            o_xlat_req <= sel_tag && i_we && assoc && i_xlat_en; // [R11]
            o_xlat_vpn <= i_wdata[`TAG_HI:`TAG_LO]; // [R6] [R11]
            multi_exc <= 1'b0;
         end
         if (state == ST_XLAT && i_xlat_done)
         begin
            o_xlat_req <= 1'b0;
            cmp_tag <= i_xlat_ptag; // [R11]
            multi_exc <= i_xlat_multi; // [R15]
         end
      end
   end

   // write-back streaming
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         hit_way <= 1'b0;
         wb_cnt <= 3'h0;
         o_wb_valid <= 1'b0;
         o_wb_addr <= 32'h0000_0000;
         o_wb_data <= 32'h0000_0000;
      end
      else
      begin
         if (state == ST_LOOK)
         begin
            hit_way <= do_assoc ? sel_hit_way : wb_way;
            wb_cnt <= 3'h0;
         end
         if (state == ST_WB_RD)
         begin
            o_wb_valid <= 1'b1; // [R9] [R13]
            o_wb_data <= op_rdata;
            o_wb_addr <= {tag_mem[hit_way][ent], ent[7:0], wb_cnt, 2'b00};
         end
         if (state == ST_WB_SEND && i_wb_ready)
         begin
            o_wb_valid <= 1'b0;
            wb_cnt <= wb_cnt + 3'd1;
         end
      end
   end

   // tag array updates; no reset on arrays, valid bits cleared by software
   always_ff @(posedge i_clk_sys)
   begin
      if (state == ST_COMMIT)
      begin
         if (do_assoc)
         begin
            dirty_mem[hit_way][ent] <= wdirty; // [R12]
            valid_mem[hit_way][ent] <= wvalid; // [R12]
         end
         else
         begin
            tag_mem[wb_way][ent] <= cmp_tag; // [R8]
            dirty_mem[wb_way][ent] <= wdirty; // [R8]
            valid_mem[wb_way][ent] <= wvalid; // [R8]
         end
      end
   end

   // read answers; a tag word comes straight from the array, never associatively
   wire tag_rd = take && sel_tag && !i_we; // [R7]
   // unmapped reads answer zero
   wire blank_rd = take && !hit_area; // [R1]
   wire [31:0] tag_word = pack_tag(tag_mem[way_sel][ent_sel], dirty_mem[way_sel][ent_sel],
      valid_mem[way_sel][ent_sel]); // [R5] [R7]
   wire [31:0] arr_word = rd_op ? op_rdata : ins_rdata; // [R18]

   // answer: ack one cycle, read data held until next answer
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         o_ack <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_multi_hit_exc <= 1'b0;
      end
      else
      begin
         o_ack <= (state == ST_DONE);
         o_multi_hit_exc <= (state == ST_DONE) && multi_exc; // [R15]
         if (tag_rd)
            o_rdata <= tag_word; // [R7]
         else if (state == ST_RDWAIT)
            o_rdata <= arr_word; // [R18]
         else if (blank_rd)
            o_rdata <= {31'h0000_0000, unused_ok & 1'b0};
      end
   end
endmodule : mapped_cache_array_access
`default_nettype wire

// *** verification/mapped_cache_array_access_properties.sv ***
// Purpose: port timing checks for the mapped cache array access port
// Assumes: requester drops its request on the acknowledge cycle
// Notes: latencies follow the port contract
`timescale 1ns/10ps
`default_nettype none
module mapped_cache_array_access_checker (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_xlat_en,
   input wire logic o_xlat_req,
   input wire logic [21:0] o_xlat_vpn,
   input wire logic i_xlat_done,
   input wire logic o_ack,
   input wire logic [31:0] o_rdata,
   input wire logic o_multi_hit_exc,
   input wire logic o_wb_valid,
   input wire logic [31:0] o_wb_addr,
   input wire logic [31:0] o_wb_data,
   input wire logic i_wb_ready
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);
   AST_ACK_PULSE: assert property (o_ack |=> !o_ack) else $error("ack held too long");
   AST_TAG_READ_LAT: assert property ($rose(i_req) && !i_we && i_addr[31:24] == 8'hF4 |-> ##2 o_ack)
      else $error("tag read answer late");
   AST_DATA_READ_LAT: assert property ($rose(i_req) && !i_we && i_addr[31:24] == 8'hF5 |-> ##3 o_ack)
      else $error("data read answer late");
   AST_UNMAPPED: assert property ($rose(i_req) && !i_we && !(i_addr[31:24] inside {8'hF4, 8'hF5, 8'hF1})
      |-> ##2 o_ack && o_rdata == 32'h0000_0000) else $error("unmapped read not empty");
   AST_XLAT_VPN: assert property (o_xlat_req |-> i_xlat_en && o_xlat_vpn == i_wdata[31:10])
      else $error("translation request wrong");
   AST_XLAT_HOLD: assert property (o_xlat_req && !i_xlat_done |=> o_xlat_req) else $error("xlat dropped");
   AST_EXC_ACK: assert property (o_multi_hit_exc |-> o_ack) else $error("exception without ack");
   AST_WB_HOLD: assert property (o_wb_valid && !i_wb_ready |=> o_wb_valid && $stable(o_wb_addr)
      && $stable(o_wb_data)) else $error("write-back word not held");
   AST_WB_STALL: assert property (o_wb_valid |-> !o_ack) else $error("ack during write-back");
   cover property (o_wb_valid && i_wb_ready);
   cover property (o_multi_hit_exc);
   cover property ($fell(o_xlat_req));
endmodule : mapped_cache_array_access_checker
bind mapped_cache_array_access mapped_cache_array_access_checker i_chk (.*);
`default_nettype wire

// *** verification/cache_far_side_model.sv ***
// Purpose: translation buffer and write-back sink model
// Assumes: one translation at a time
// Notes: ready stalls at random so beats are held
`timescale 1ns/10ps
`default_nettype none
module cache_far_side_model (
   input wire logic i_clk_sys,
   input wire logic i_xlat_req,
   input wire logic i_hit,
   input wire logic i_multi,
   input wire logic [18:0] i_ptag,
   output logic o_done,
   output logic o_hit,
   output logic o_multi,
   output logic [18:0] o_ptag,
   output logic o_wb_ready
);
   int seed = 32'h2d2a_0dc5;
   initial {o_done, o_hit, o_multi, o_ptag, o_wb_ready} = '0;
   always @(posedge i_clk_sys)
   begin
      o_wb_ready <= ($random(seed) & 3) != 0;
      o_done <= i_xlat_req && !o_done && ($random(seed) & 1);
      o_ptag <= i_xlat_req ? i_ptag : ~o_ptag; // junk outside an answer
      o_hit <= i_hit;
      o_multi <= i_multi;
   end
endmodule : cache_far_side_model
`default_nettype wire

// *** verification/mapped_cache_array_access_tb.sv ***
// Purpose: self-checking bench for the mapped cache array access port
// Assumes: tag arrays start unknown and are cleared first
// Notes: write-back beats are gathered as they are accepted
`timescale 1ns/10ps
`default_nettype none
module mapped_cache_array_access_tb;
   logic i_clk_sys = 0, i_sys_rst = 1, i_req = 0, i_we = 0, i_ram_mode_bit = 0, i_index_mode_bit = 0;
   logic i_xlat_en = 0, o_xlat_req, i_xlat_done, i_xlat_hit, i_xlat_multi, o_ack, o_multi_hit_exc;
   logic o_wb_valid, i_wb_ready, hit_sel = 1, multi_sel = 0, exc_seen;
   logic [31:0] i_addr = 0, i_wdata = 0, o_rdata, o_wb_addr, o_wb_data, r, d;
   logic [21:0] o_xlat_vpn;
   logic [18:0] i_xlat_ptag, ptag_sel = 0;
   logic [31:0] dm [int];
   logic [31:0] wq [$], dq [$];
   int fail_count = 0, checked = 0, seed = 32'h2d2a_0dc5, e, n;
   always #25 i_clk_sys = ~i_clk_sys;
   mapped_cache_array_access i_dut (.*);
   cache_far_side_model i_far (.i_clk_sys(i_clk_sys), .i_xlat_req(o_xlat_req), .i_hit(hit_sel),
      .i_multi(multi_sel), .i_ptag(ptag_sel), .o_done(i_xlat_done), .o_hit(i_xlat_hit),
      .o_multi(i_xlat_multi), .o_ptag(i_xlat_ptag), .o_wb_ready(i_wb_ready));
   always @(posedge i_clk_sys)
      if (o_wb_valid === 1'b1 && i_wb_ready === 1'b1)
      begin
         wq.push_back(o_wb_addr);
         dq.push_back(o_wb_data);
      end
   function automatic logic [31:0] ta(input logic [7:0] c, input int w, input int en, input int lw);
      return {c, 9'($random(seed)), w[0], en[8:0], lw[2:0], 2'b00}; // random shadow block
   endfunction : ta
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      $display("compares %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic acc(input logic we, input logic [31:0] a, input logic [31:0] dat);
      int k = 0;
      i_req <= 1'b1;
      i_we <= we;
      i_addr <= a;
      i_wdata <= dat;
      i_index_mode_bit <= 1'($random(seed));
      do
      begin
         @(posedge i_clk_sys);
         k++;
      end
      while (o_ack !== 1'b1 && k < 3000);
      r = o_rdata;
      exc_seen = o_multi_hit_exc;
      i_req <= 1'b0;
      if (k >= 3000)
      begin
         fail_count++;
         give_verdict();
      end
      @(posedge i_clk_sys);
   endtask : acc
   task automatic fill(input int w, input int en);
      for (int lw = 0; lw < 8; lw++)
      begin
         dm[w*4096+en*8+lw] = $random(seed);
         acc(1, ta(8'hF5, w, en, lw), dm[w*4096+en*8+lw]);
      end
   endtask : fill
   task automatic tagw(input int w, input int en, input int lw, input logic [18:0] tg, input logic [1:0] uv);
      wq = {};
      dq = {};
      acc(1, ta(8'hF4, w, en, lw), {3'($random(seed)), tg, 8'($random(seed)), uv});
   endtask : tagw
   task automatic tagchk(input int w, input int en, input logic [18:0] tg, input logic [1:0] uv);
      acc(0, ta(8'hF4, w, en, 2), 0);
      check({r[28:10], r[1:0]}, {tg, uv});
   endtask : tagchk
   task automatic wbchk(input int w, input int en, input logic [18:0] tg, input int cnt);
      check(wq.size(), cnt);
      for (int i = 0; i < cnt && i < wq.size(); i++)
      begin
         check(wq[i], {tg, 8'(en), 3'(i), 2'b00});
         check(dq[i], dm[w*4096+en*8+i]);
      end
   endtask : wbchk
   initial
   begin
      repeat (5) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(posedge i_clk_sys);
      for (int k = 0; k < 1024; k++)
         tagw(k / 512, k % 512, 0, 0, 2'b00);
      for (int k = 0; k < 48; k++)
      begin
         e = $random(seed) & 511;
         fill(k & 1, e);
         d = $random(seed);
         acc(1, {8'hF1, 10'($random(seed)), k[0], e[7:0], k[2:0], 2'b00}, d);
         acc(0, {8'hF1, 10'($random(seed)), k[0], e[7:0], k[2:0], 2'b00}, 0);
         check(r, d);
      end
      foreach (dm[key])
      begin
         acc(0, ta(8'hF5, key / 4096, (key / 8) % 512, key % 8), 0);
         check(r, dm[key]);
      end
      tagw(1, 300, 0, 19'h1_2345, 2'b01);
      fill(1, 300);
      tagw(1, 300, 0, 19'h0_0abc, 2'b11);
      wbchk(1, 300, 0, 0);
      tagw(1, 300, 0, 19'h3_0001, 2'b00);
      wbchk(1, 300, 19'h0_0abc, 8);
      tagchk(1, 300, 19'h3_0001, 2'b00);
      tagw(0, 301, 0, 19'h5_5555, 2'b11);
      fill(0, 301);
      tagw(1, 301, 2, 19'h5_5554, 2'b00);
      wbchk(0, 301, 0, 0);
      tagchk(0, 301, 19'h5_5555, 2'b11);
      tagw(1, 301, 2, 19'h5_5555, 2'b10);
      wbchk(0, 301, 19'h5_5555, 8);
      tagchk(0, 301, 19'h5_5555, 2'b10);
      i_xlat_en <= 1'b1;
      tagw(0, 302, 0, 19'h0_7777, 2'b01);
      ptag_sel <= 19'h0_7777;
      for (int k = 0; k < 3; k++)
      begin
         hit_sel <= k != 0;
         multi_sel <= k == 1;
         tagw(1, 302, 2, 19'h7_0f0f, 2'b00);
         check(exc_seen, k == 1);
         tagchk(0, 302, 19'h0_7777, {1'b0, k != 2}); // miss and multi hit leave the line
      end
      i_xlat_en <= 1'b0;
      i_ram_mode_bit <= 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         d = $random(seed);
         n = $random(seed) & 4095;
         acc(1, {8'hF5, 10'($random(seed)), n[11:0], 2'b00}, d);
         acc(0, {8'hF5, 10'($random(seed)), n[11:0], 2'b00}, 0);
         check(r, d);
      end
      acc(0, 32'hf200_0100, 0);
      check(r, 0);
      give_verdict();
   end
endmodule : mapped_cache_array_access_tb
`default_nettype wire
